// [design/sfpe_ctrl.sv]
/*
  Host controller that programs and erases a serial NOR flash and moves
  it in and out of deep power-down. Software talks to it through a plain
  register port; the flash is driven over chip select, clock, four lanes.
  Assumes one 125 MHz clock and flash pins synchronous to it.
*/
`timescale 1ns/1ps
module sfpe_ctrl #(
  parameter int DP_CYCLES   = sfpe_pkg::DP_CYC,
  parameter int RES1_CYCLES = sfpe_pkg::RES1_CYC,
  parameter int DESEL_CYCLES = sfpe_pkg::DESEL_CYC,
  parameter int SCLK_HALF   = sfpe_pkg::SCLK_HALF
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic  [3:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             flash_cs_n,
  output logic             flash_sclk,
  output logic       [3:0] flash_io_o,
  output logic       [3:0] flash_io_oe,
  input  wire logic  [3:0] flash_io_i
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] opcode(input sfpe_pkg::sfpe_st_t st,
                                        input logic [2:0] op,
                                        input logic alt);
    logic [7:0] o;
    o = sfpe_pkg::OPC_RDSR1;
    case (st)
      sfpe_pkg::S_CHKQE: o = sfpe_pkg::OPC_RDSR2;
      sfpe_pkg::S_WRITE_ENABLE_CMD:  o = sfpe_pkg::OPC_WRITE_ENABLE_CMD;
      sfpe_pkg::S_DPCMD: o = sfpe_pkg::OPC_DPD;
      sfpe_pkg::S_RES:   o = sfpe_pkg::OPC_WAKE;
      sfpe_pkg::S_CMD:
        case (op)
          sfpe_pkg::OP_PROG:  o = sfpe_pkg::OPC_QPP;
          sfpe_pkg::OP_SECT:  o = sfpe_pkg::OPC_SECT;
          sfpe_pkg::OP_BLK32: o = sfpe_pkg::OPC_BLK32;
          sfpe_pkg::OP_BLK64: o = sfpe_pkg::OPC_BLK64;
          default: o = alt ? sfpe_pkg::OPC_CHIP_B : sfpe_pkg::OPC_CHIP_A;
        endcase
      default: o = sfpe_pkg::OPC_RDSR1;
    endcase
    return o;
  endfunction

  // bytes in a frame, opcode included
  function automatic logic [8:0] frame_len(input sfpe_pkg::sfpe_st_t st,
                                           input logic [2:0] op,
                                           input logic [8:0] cnt);
    logic [8:0] n;
    n = 9'h001;
    case (st)
      sfpe_pkg::S_CHKQE,
      sfpe_pkg::S_POLL,
      sfpe_pkg::S_CHKWIP: n = 9'h002;
      sfpe_pkg::S_CMD:
        case (op)
          sfpe_pkg::OP_PROG: n = 9'h004 + cnt;
          sfpe_pkg::OP_CHIP: n = 9'h001;
          default:           n = 9'h004;
        endcase
      default: n = 9'h001;
    endcase
    return n;
  endfunction

  function automatic sfpe_pkg::sfpe_st_t first_state(input logic [2:0] op);
    sfpe_pkg::sfpe_st_t s;
    case (op)
      sfpe_pkg::OP_PROG: s = sfpe_pkg::S_CHKQE;
      sfpe_pkg::OP_DPD:  s = sfpe_pkg::S_CHKWIP;
      sfpe_pkg::OP_WAKE: s = sfpe_pkg::S_RES;
      default:           s = sfpe_pkg::S_WRITE_ENABLE_CMD;
    endcase
    return s;
  endfunction

  // ---------------------------------------------------------------
  // state and storage
  // ---------------------------------------------------------------
  sfpe_pkg::sfpe_st_t st_r;
  sfpe_pkg::sfpe_st_t st_nxt;
  sfpe_pkg::sfpe_fr_t fr_r;
  logic [2:0]  op_r;
  logic        alt_r;
  logic [23:0] addr_r;
  logic [8:0]  cnt_r;
  logic [8:0]  idx_r;
  logic [7:0]  gap_r;
  logic [15:0] tmr_r;
  logic [7:0]  sr1_r;
  logic [7:0]  sr2_r;
  logic        cs_n_r;
  logic        pd_r;
  logic        ref_r;
  logic        done_r;
  logic        qe_err_r;
  logic [31:0] rdata_r;
  logic [7:0]  page_mem [0:sfpe_pkg::PAGE_BYTES-1];

  logic        sh_done;
  logic [7:0]  sh_rx;

  // ---------------------------------------------------------------
  // register port decode
  // ---------------------------------------------------------------
  wire        busy     = st_r != sfpe_pkg::S_IDLE;
  wire        wr_ctrl  = reg_wr && reg_addr == sfpe_pkg::REG_CTRL;
  wire        wr_addr  = reg_wr && reg_addr == sfpe_pkg::REG_ADDR;
  wire        wr_data  = reg_wr && reg_addr == sfpe_pkg::REG_DATA;
  wire        wr_stat  = reg_wr && reg_addr == sfpe_pkg::REG_STAT;
  wire [2:0]  req_op   = reg_wdata[2:0];
  wire        page_full = cnt_r == 9'(sfpe_pkg::PAGE_BYTES);
  // asleep flash answers only the wake command
  wire        pd_block = pd_r && req_op != sfpe_pkg::OP_WAKE;
  wire        empty_pp = req_op == sfpe_pkg::OP_PROG && cnt_r == 9'h000;
  wire        start_ok = wr_ctrl && req_op != sfpe_pkg::OP_NONE && !busy
                         && !pd_block && !empty_pp;
  wire        start_bad = wr_ctrl && req_op != sfpe_pkg::OP_NONE && !start_ok;
  // more than one page is never sent, so nothing is silently dropped
  wire        push_ok  = wr_data && !busy && !page_full;
  wire        push_bad = wr_data && !push_ok;
  wire        flush    = wr_ctrl && !busy && reg_wdata[sfpe_pkg::CTRL_FLUSH_BIT];

  // ---------------------------------------------------------------
  // frame decode
  // ---------------------------------------------------------------
  wire        in_frame = st_r != sfpe_pkg::S_IDLE && st_r != sfpe_pkg::S_WAIT;
  wire        fr_go    = in_frame && fr_r == sfpe_pkg::FR_IDLE;
  wire        fr_done  = fr_r == sfpe_pkg::FR_GAP && gap_r == 8'h00;
  wire [8:0]  fr_len   = frame_len(st_r, op_r, cnt_r);
  wire        fr_last  = idx_r == fr_len - 9'h001;
  wire [7:0]  data_ix  = 8'(idx_r - 9'h004);
  wire [7:0]  tx_byte  = idx_r == 9'h000 ? opcode(st_r, op_r, alt_r) :
                         idx_r == 9'h001 ? addr_r[23:16] :
                         idx_r == 9'h002 ? addr_r[15:8] :
                         idx_r == 9'h003 ? addr_r[7:0] :
                                           page_mem[data_ix];
  // data bytes of the page program go out on all four lanes
  wire        tx_quad  = st_r == sfpe_pkg::S_CMD && op_r == sfpe_pkg::OP_PROG
                         && idx_r >= 9'h004;
  wire        rx_wip   = sh_rx[sfpe_pkg::SR1_WIP_BIT];
  wire        rx_qe    = sh_rx[sfpe_pkg::SR2_QE_BIT];
  wire        qe_fail  = st_r == sfpe_pkg::S_CHKQE && fr_done && !rx_qe;
  wire        wip_fail = st_r == sfpe_pkg::S_CHKWIP && fr_done && rx_wip;
  wire        poll_end = st_r == sfpe_pkg::S_POLL && fr_done && !rx_wip;
  wire        wait_end = st_r == sfpe_pkg::S_WAIT && tmr_r == 16'h0000;
  wire        op_end   = poll_end || wait_end;

  // ---------------------------------------------------------------
  // byte shifter
  // ---------------------------------------------------------------
  sfpe_shift #(
    .HALF_CYC (SCLK_HALF)
  ) u_shift (
    .clk     (clk),
    .arst_n  (arst_n),
    .start   (fr_r == sfpe_pkg::FR_LOAD),
    .quad    (tx_quad),
    .tx_byte (tx_byte),
    .io_i    (flash_io_i),
    .done    (sh_done),
    .rx_byte (sh_rx),
    .sclk    (flash_sclk),
    .io_o    (flash_io_o),
    .io_oe   (flash_io_oe)
  );

  // ---------------------------------------------------------------
  // operation sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      sfpe_pkg::S_IDLE:   if (start_ok) st_nxt = first_state(req_op);
      sfpe_pkg::S_CHKQE:  if (fr_done) st_nxt = rx_qe ? sfpe_pkg::S_WRITE_ENABLE_CMD : sfpe_pkg::S_IDLE;
      sfpe_pkg::S_WRITE_ENABLE_CMD:   if (fr_done) st_nxt = sfpe_pkg::S_CMD;
      sfpe_pkg::S_CMD:    if (fr_done) st_nxt = sfpe_pkg::S_POLL;
      // busy flag decides; the latch drop inside the cycle needs no action
      sfpe_pkg::S_POLL:   if (poll_end) st_nxt = sfpe_pkg::S_IDLE;
      sfpe_pkg::S_CHKWIP: if (fr_done) st_nxt = rx_wip ? sfpe_pkg::S_IDLE : sfpe_pkg::S_DPCMD;
      sfpe_pkg::S_DPCMD:  if (fr_done) st_nxt = sfpe_pkg::S_WAIT;
      sfpe_pkg::S_RES:    if (fr_done) st_nxt = sfpe_pkg::S_WAIT;
      sfpe_pkg::S_WAIT:   if (wait_end) st_nxt = sfpe_pkg::S_IDLE;
      default:            st_nxt = sfpe_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_r <= sfpe_pkg::S_IDLE;
    else
      st_r <= st_nxt;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      op_r   <= sfpe_pkg::OP_NONE;
      alt_r  <= 1'b0;
      addr_r <= 24'h000000;
    end
    else
    begin
      if (start_ok)
      begin
        op_r  <= req_op;
        alt_r <= reg_wdata[sfpe_pkg::CTRL_ALT_BIT];
      end
      if (wr_addr && !busy)
        addr_r <= reg_wdata[23:0];
    end
  end

  // ---------------------------------------------------------------
  // frame engine
  // ---------------------------------------------------------------
  // select stays low from opcode to last byte, rises the cycle after the
  // final bit so the flash sees a clean byte boundary
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fr_r   <= sfpe_pkg::FR_IDLE;
      cs_n_r <= 1'b1;
      idx_r  <= 9'h000;
      gap_r  <= 8'h00;
    end
    else
    begin
      case (fr_r)
        sfpe_pkg::FR_IDLE:
          if (fr_go)
          begin
            cs_n_r <= 1'b0;
            idx_r  <= 9'h000;
            fr_r   <= sfpe_pkg::FR_LOAD;
          end
        sfpe_pkg::FR_LOAD:
          fr_r <= sfpe_pkg::FR_BUSY;
        sfpe_pkg::FR_BUSY:
          if (sh_done && fr_last)
          begin
            cs_n_r <= 1'b1;
            gap_r  <= 8'(DESEL_CYCLES - 1);
            fr_r   <= sfpe_pkg::FR_GAP;
          end
          else if (sh_done)
          begin
            idx_r <= idx_r + 9'h001;
            fr_r  <= sfpe_pkg::FR_LOAD;
          end
        sfpe_pkg::FR_GAP:
          if (gap_r == 8'h00)
            fr_r <= sfpe_pkg::FR_IDLE;
          else
            gap_r <= gap_r - 8'h01;
        default:
          fr_r <= sfpe_pkg::FR_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // power-down timer and state
  // ---------------------------------------------------------------
  // select stays high through the whole wait, as the release demands
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tmr_r <= 16'h0000;
    else if (st_r == sfpe_pkg::S_DPCMD && fr_done)
      tmr_r <= 16'(DP_CYCLES - 1);
    else if (st_r == sfpe_pkg::S_RES && fr_done)
      tmr_r <= 16'(RES1_CYCLES - 1);
    else if (st_r == sfpe_pkg::S_WAIT && tmr_r != 16'h0000)
      tmr_r <= tmr_r - 16'h0001;
  end

  // flash wakes in standby after power-up, so reset assumes awake
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pd_r <= 1'b0;
    else if (wait_end)
      pd_r <= op_r == sfpe_pkg::OP_DPD;
  end

  // ---------------------------------------------------------------
  // page buffer
  // ---------------------------------------------------------------
  // no reset on the array: contents are only read below cnt_r
  always_ff @(posedge clk)
  begin
    if (push_ok)
      page_mem[cnt_r[7:0]] <= reg_wdata[7:0];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_r <= 9'h000;
    else if (flush || (poll_end && op_r == sfpe_pkg::OP_PROG))
      cnt_r <= 9'h000;
    else if (push_ok)
      cnt_r <= cnt_r + 9'h001;
  end

  // ---------------------------------------------------------------
  // status capture and sticky flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sr1_r <= 8'h00;
      sr2_r <= 8'h00;
    end
    else if (fr_done && st_r == sfpe_pkg::S_CHKQE)
      sr2_r <= sh_rx;
    else if (fr_done && (st_r == sfpe_pkg::S_POLL || st_r == sfpe_pkg::S_CHKWIP))
      sr1_r <= sh_rx;
  end

  // set wins over a clear written in the same cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ref_r    <= 1'b0;
      done_r   <= 1'b0;
      qe_err_r <= 1'b0;
    end
    else
    begin
      ref_r    <= start_bad || push_bad || qe_fail || wip_fail ||
                  (ref_r && !(wr_stat && reg_wdata[sfpe_pkg::STAT_REF_BIT]));
      done_r   <= op_end ||
                  (done_r && !(wr_stat && reg_wdata[sfpe_pkg::STAT_DONE_BIT]));
      qe_err_r <= qe_fail ||
                  (qe_err_r && !(wr_stat && reg_wdata[sfpe_pkg::STAT_QE_BIT]));
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  wire [31:0] stat_word = {8'h00, sr2_r, sr1_r, 3'h0, qe_err_r, done_r,
                           ref_r, pd_r, busy};
  wire [31:0] rd_mux    =
    reg_addr == sfpe_pkg::REG_CTRL ? {22'h000000, alt_r, 6'h00, op_r} :
    reg_addr == sfpe_pkg::REG_ADDR ? {8'h00, addr_r} :
    reg_addr == sfpe_pkg::REG_DATA ? {23'h000000, cnt_r} :
    reg_addr == sfpe_pkg::REG_STAT ? stat_word : 32'h00000000;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_r <= 32'h00000000;
    else
      rdata_r <= reg_rd ? rd_mux : 32'h00000000;
  end

  assign reg_rdata  = rdata_r;
  assign flash_cs_n = cs_n_r;

endmodule

// [design/sfpe_pkg.sv]
/*
  Constants and types for the serial flash program/erase host controller:
  flash opcodes, the controller's own register map, field positions and
  timing counts. Assumes a 125 MHz system clock.
*/
// Summary of operation
// - quad page program needs quad enable bit 9 set
// - write enable command precedes every program or erase
// - quad program: opcode 32H, address, quad data
// - program runs only if select rises on byte boundary
// - host polls busy flag in status register
// - sector erase: 20H plus three address bytes
// - erase runs only if select rises after address
// - 32KB block erase: 52H plus address
// - 64KB block erase: D8H plus address
// - chip erase: 60H or C7H, bare opcode
// - select held low for whole command sequence
// - wake with ABH, select high for release time
package sfpe_pkg;

  // ---------------------------------------------------------------
  // flash opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD   = 8'h06;
  localparam logic [7:0] OPC_RDSR1  = 8'h05;
  localparam logic [7:0] OPC_RDSR2  = 8'h35;
  localparam logic [7:0] OPC_QPP    = 8'h32;
  localparam logic [7:0] OPC_SECT   = 8'h20;
  localparam logic [7:0] OPC_BLK32  = 8'h52;
  localparam logic [7:0] OPC_BLK64  = 8'hD8;
  localparam logic [7:0] OPC_CHIP_A = 8'h60;
  localparam logic [7:0] OPC_CHIP_B = 8'hC7;
  localparam logic [7:0] OPC_DPD    = 8'hB9;
  localparam logic [7:0] OPC_WAKE   = 8'hAB;

  // ---------------------------------------------------------------
  // controller register map and fields
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;

  localparam logic [2:0] OP_NONE  = 3'h0;
  localparam logic [2:0] OP_PROG  = 3'h1;
  localparam logic [2:0] OP_SECT  = 3'h2;
  localparam logic [2:0] OP_BLK32 = 3'h3;
  localparam logic [2:0] OP_BLK64 = 3'h4;
  localparam logic [2:0] OP_CHIP  = 3'h5;
  localparam logic [2:0] OP_DPD   = 3'h6;
  localparam logic [2:0] OP_WAKE  = 3'h7;

  localparam int CTRL_ALT_BIT   = 8;
  localparam int CTRL_FLUSH_BIT = 9;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_PD_BIT    = 1;
  localparam int STAT_REF_BIT   = 2;
  localparam int STAT_DONE_BIT  = 3;
  localparam int STAT_QE_BIT    = 4;
  localparam int SR1_WIP_BIT    = 0;
  localparam int SR2_QE_BIT     = 1;
  localparam int PAGE_BYTES     = 256;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ    = 125;
  localparam int T_DP_NS    = 3000;
  localparam int T_RES1_NS  = 20000;
  localparam int T_DESEL_NS = 50;
  localparam int DP_CYC     = (T_DP_NS * CLK_MHZ + 999) / 1000;
  localparam int RES1_CYC   = (T_RES1_NS * CLK_MHZ + 999) / 1000;
  localparam int DESEL_CYC  = (T_DESEL_NS * CLK_MHZ + 999) / 1000;
  localparam int SCLK_HALF  = 2;

  typedef enum logic [3:0] {
    S_IDLE   = 4'h0,
    S_CHKQE  = 4'h1,
    S_WRITE_ENABLE_CMD   = 4'h2,
    S_CMD    = 4'h3,
    S_POLL   = 4'h4,
    S_CHKWIP = 4'h5,
    S_DPCMD  = 4'h6,
    S_RES    = 4'h7,
    S_WAIT   = 4'h8
  } sfpe_st_t;

  typedef enum logic [1:0] {
    FR_IDLE = 2'h0,
    FR_LOAD = 2'h1,
    FR_BUSY = 2'h2,
    FR_GAP  = 2'h3
  } sfpe_fr_t;

endpackage

// [design/sfpe_shift.sv]
/*
  Byte shifter for the serial flash link: SPI mode 0, one lane or four.
  Assumes the caller starts a byte only while it is idle and keeps chip
  select low around it; flash outputs are synchronous to clk.
*/
`timescale 1ns/1ps
module sfpe_shift #(
  parameter int HALF_CYC = 2
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       start,
  input  wire logic       quad,
  input  wire logic [7:0] tx_byte,
  input  wire logic [3:0] io_i,
  output logic            done,
  output logic      [7:0] rx_byte,
  output logic            sclk,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe
);

  logic       act_r;
  logic       sclk_r;
  logic       quad_r;
  logic       done_r;
  logic [7:0] sh_r;
  logic [7:0] rx_r;
  logic [3:0] bits_r;
  logic [7:0] div_r;
  wire        quad_on = act_r && quad_r;

  // ---------------------------------------------------------------
  // shift engine
  // ---------------------------------------------------------------
  // data changes on the falling edge, flash samples on the rising edge
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      act_r  <= 1'b0;
      sclk_r <= 1'b0;
      quad_r <= 1'b0;
      done_r <= 1'b0;
      sh_r   <= 8'h00;
      rx_r   <= 8'h00;
      bits_r <= 4'h0;
      div_r  <= 8'h00;
    end
    else
    begin
      done_r <= 1'b0;
      if (start && !act_r)
      begin
        act_r  <= 1'b1;
        sh_r   <= tx_byte;
        quad_r <= quad;
        bits_r <= quad ? 4'h2 : 4'h8;
        div_r  <= 8'(HALF_CYC - 1);
        sclk_r <= 1'b0;
      end
      else if (act_r)
      begin
        if (div_r != 8'h00)
          div_r <= div_r - 8'h01;
        else
        begin
          div_r  <= 8'(HALF_CYC - 1);
          sclk_r <= ~sclk_r;
          if (!sclk_r)
            rx_r <= {rx_r[6:0], io_i[1]};
          else
          begin
            sh_r   <= quad_r ? {sh_r[3:0], 4'h0} : {sh_r[6:0], 1'b0};
            bits_r <= bits_r - 4'h1;
            if (bits_r == 4'h1)
            begin
              act_r  <= 1'b0;
              done_r <= 1'b1;
            end
          end
        end
      end
    end
  end

  // io2/io3 held high in single-lane mode so write-protect and hold stay idle
  assign io_o    = quad_on ? sh_r[7:4] : {2'b11, 1'b0, sh_r[7]};
  assign io_oe   = quad_on ? 4'hF : 4'hD;
  assign sclk    = sclk_r;
  assign done    = done_r;
  assign rx_byte = rx_r;

endmodule

// [tb/sfpe_ctrl_properties.sv]
/* port timing checker for sfpe_ctrl.
   bound to every sfpe_ctrl; sees its ports only, one clock. */
`timescale 1ns/1ps
module sfpe_ctrl_properties (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic  [3:0] reg_addr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        flash_cs_n,
  input wire logic        flash_sclk,
  input wire logic  [3:0] flash_io_o,
  input wire logic  [3:0] flash_io_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_busy;
    reg_rd && reg_addr == sfpe_pkg::REG_STAT && !flash_cs_n |=> reg_rdata[0];
  endproperty
  a_busy: assert property (p_busy) else $error("busy low during frame");
  property p_sclk_cs;
    flash_cs_n |-> !flash_sclk;
  endproperty
  a_sclk_cs: assert property (p_sclk_cs) else $error("clock while deselected");
  property p_cs_end;
    $rose(flash_cs_n) |-> !$past(flash_sclk);
  endproperty
  a_cs_end: assert property (p_cs_end) else $error("select rose mid bit");
  property p_desel;
    $rose(flash_cs_n) |-> flash_cs_n [*3];
  endproperty
  a_desel: assert property (p_desel) else $error("deselect gap short");
  property p_half;
    $rose(flash_sclk) |-> flash_sclk [*2] ##1 !flash_sclk;
  endproperty
  a_half: assert property (p_half) else $error("clock high time wrong");
  property p_idle_lanes;
    flash_io_oe == 4'hD |-> flash_io_o[3:2] == 2'h3;
  endproperty
  a_idle_lanes: assert property (p_idle_lanes) else $error("spare lanes not high");
  property p_io_hold;
    flash_sclk |-> $stable(flash_io_o) && $stable(flash_io_oe);
  endproperty
  a_io_hold: assert property (p_io_hold) else $error("lanes moved while high");
  property p_quad_cs;
    flash_io_oe == 4'hF |-> !flash_cs_n;
  endproperty
  a_quad_cs: assert property (p_quad_cs) else $error("quad drive outside frame");
endmodule
bind sfpe_ctrl sfpe_ctrl_properties u_props (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_cs_n(flash_cs_n), .flash_sclk(flash_sclk),
  .flash_io_o(flash_io_o), .flash_io_oe(flash_io_oe));

// [tb/sfpe_ctrl_tb.sv]
/* self-checking bench for sfpe_ctrl with a behavioural flash.
   short delay parameters keep the run brief. */
`timescale 1ns/1ps
module sfpe_ctrl_tb;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] st;
  logic [3:0]  io_o;
  logic [3:0]  io_oe;
  logic [3:0]  io_i;
  logic        cs_n;
  logic        sclk;
  logic        so;
  logic [7:0]  pat [3] = '{8'hA5, 8'h3C, 8'h0F};
  int          sz [3] = '{'h1000, 'h8000, 'h10000};
  int          n_errors = 0;
  int          tests_run = 0;
  always #4 clk = ~clk;
  assign io_i = {io_o[3:2], io_oe[1] ? io_o[1] : so, io_o[0]};
  sfpe_ctrl #(.DP_CYCLES(4), .RES1_CYCLES(8), .DESEL_CYCLES(2)) dut (.clk(clk),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_cs_n(cs_n),
    .flash_sclk(sclk), .flash_io_o(io_o), .flash_io_oe(io_oe), .flash_io_i(io_i));
  sfpe_flash_model fl (.cs_n(cs_n), .sclk(sclk), .io(io_i), .so(so));
  task end_of_test;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 st = reg_rdata;
  endtask
  // start an operation, poll until idle, then clear sticky flags
  task run(input logic [31:0] c);
    wr(sfpe_pkg::REG_CTRL, c);
    repeat (2) @(posedge clk);
    repeat (3000)
    begin
      rd(sfpe_pkg::REG_STAT);
      if (st[0] === 1'b0) break;
    end
    chk("busy", st[0], 0);
    wr(sfpe_pkg::REG_STAT, 32'h1C);
  endtask
  task push(input int a, input int k);
    wr(sfpe_pkg::REG_CTRL, 32'h200);
    wr(sfpe_pkg::REG_ADDR, a);
    for (int i = 0; i < k; i++) wr(sfpe_pkg::REG_DATA, pat[i]);
  endtask
  initial
  begin
    #400000;
    n_errors++;
    end_of_test;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(sfpe_pkg::REG_STAT);
    chk("stat_rst", st[4:0], 0);
    push('h10, 3);
    run(sfpe_pkg::OP_PROG);
    chk("done", st[3], 1);
    for (int i = 0; i < 3; i++) chk("prog", fl.rd('h10 + i), pat[i]);
    chk("keep", fl.rd('h13), 8'hFF);
    chk("wel", fl.write_enable_latch, 0);
    fl.qe = 1'b0;
    push('h11, 1);
    run(sfpe_pkg::OP_PROG);
    chk("qe_flag", st[4], 1);
    chk("qe_mem", fl.rd('h11), 8'h3C);
    fl.qe = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      fl.mem['h20000] = 8'h00;
      fl.mem['h20000 + sz[i]] = 8'h00;
      wr(sfpe_pkg::REG_ADDR, 'h20000 + sz[i] - 'h5A);
      run(sfpe_pkg::OP_SECT + i);
      chk("wipe", fl.rd('h20000), 8'hFF);
      chk("wipe_out", fl.rd('h20000 + sz[i]), 8'h00);
    end
    fl.bp = 5'h01;
    fl.mem['h40000] = 8'h00;
    push('h40001, 1);
    run(sfpe_pkg::OP_PROG);
    chk("prot_prog", fl.rd('h40001), 8'hFF);
    run(sfpe_pkg::OP_SECT);
    chk("prot_wipe", fl.rd('h40000), 8'h00);
    run(sfpe_pkg::OP_CHIP);
    chk("prot_chip", fl.rd('h40000), 8'h00);
    fl.bp = 5'h00;
    for (int i = 0; i < 2; i++)
    begin
      fl.mem['h40000] = 8'h00;
      run(sfpe_pkg::OP_CHIP + i * 'h100);
      chk("chip", fl.rd('h40000), 8'hFF);
    end
    fl.write_in_progress = 1'b1;
    run(sfpe_pkg::OP_DPD);
    chk("dp_ref", st[2], 1);
    chk("dp_ref_pd", fl.pd, 0);
    fl.write_in_progress = 1'b0;
    run(sfpe_pkg::OP_DPD);
    chk("pd", fl.pd, 1);
    chk("pd_flag", st[1], 1);
    run(sfpe_pkg::OP_SECT);
    chk("pd_ref", st[2], 1);
    run(sfpe_pkg::OP_WAKE);
    chk("wake", fl.pd, 0);
    chk("wake_flag", st[1], 0);
    end_of_test;
  end
endmodule

// [tb/sfpe_flash_model.sv]
/* behavioural serial NOR flash: program, erase, status, power-down.
   assumes mode 0 clocking and lanes already resolved by the bench. */
`timescale 1ns/1ps
module sfpe_flash_model #(
  parameter int BUSY_NS = 400,
  parameter int T_DP    = 16
) (
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] io,
  output logic           so
);
  logic [7:0]  mem [int];
  logic [7:0]  pb [int];
  logic [7:0]  op;
  logic [7:0]  sh;
  logic [7:0]  sr;
  logic [23:0] adr;
  logic        qe = 1'b1;
  logic        write_enable_latch = 1'b0;
  logic        write_in_progress = 1'b0;
  logic        pd = 1'b0;
  logic [4:0]  bp = 5'h00;
  int          n;
  initial so = 1'b0;
  function automatic logic [7:0] rd(int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  function automatic bit prot(int a);
    return bp != 0 && a >= 'h40000;
  endfunction
  task automatic wipe(int a, int sz);
    foreach (mem[k]) if (k / sz == a / sz) mem[k] = 8'hFF;
  endtask
  task automatic busy();
    write_in_progress = 1'b1;
    #(BUSY_NS / 2) write_enable_latch = 1'b0;
    #(BUSY_NS / 2) write_in_progress = 1'b0;
  endtask
  always @(negedge cs_n)
  begin
    n = 0;
    pb.delete();
  end
  always @(posedge sclk) if (!cs_n)
  begin
    logic q;
    q = op == 8'h32 && n >= 32;
    sh = q ? {sh[3:0], io} : {sh[6:0], io[0]};
    n += q ? 4 : 1;
    if (n == 8) op = sh;
    if (n == 8) sr = sh == 8'h35 ? {6'h00, qe, 1'b0} : {1'b0, bp, write_enable_latch, write_in_progress};
    if (n % 8 == 0 && n > 8 && n <= 32) adr = {adr[15:0], sh};
    if (n % 8 == 0 && n > 32 && op == 8'h32) pb[(adr[7:0] + n / 8 - 5) % 256] = sh;
  end
  always @(negedge sclk) if (!cs_n && n >= 8) so = sr[7 - (n % 8)];
  always @(posedge cs_n)
  begin
    so = ~so;
    if (n % 8 == 0 && n > 0)
      if (pd) pd = op != 8'hAB;
      else case (op)
        8'h06: if (!write_in_progress) write_enable_latch = 1'b1;
        8'h32: if (n >= 40 && qe && write_enable_latch && !write_in_progress && !prot(adr))
        begin
          foreach (pb[k]) mem[{adr[23:8], k[7:0]}] = rd({adr[23:8], k[7:0]}) & pb[k];
          fork busy(); join_none
        end
        8'h20, 8'h52, 8'hD8: if (n == 32 && write_enable_latch && !write_in_progress && !prot(adr))
        begin
          wipe(adr, op == 8'h20 ? 'h1000 : op == 8'h52 ? 'h8000 : 'h10000);
          fork busy(); join_none
        end
        8'h60, 8'hC7: if (n == 8 && write_enable_latch && !write_in_progress && bp[2:0] == 0)
        begin
          wipe(0, 'h1000000);
          fork busy(); join_none
        end
        8'hB9: if (n == 8 && !write_in_progress) pd <= #(T_DP) 1'b1;
        default: ;
      endcase
  end
endmodule
